// ### verilog/ldfm_pkg.sv
// constants for the dominant-timeout and bus-stuck fault monitor
package ldfm_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_TIMEOUT_CONFIG = 16'hA0B0;
  localparam logic [15:0] IDX_TX_TO_LOW = 16'hA0B1;
  localparam logic [15:0] IDX_TX_TO_HIGH = 16'hA0B2;
  localparam logic [15:0] IDX_RX_TO_LOW = 16'hA0B3;
  localparam logic [15:0] IDX_RX_TO_HIGH = 16'hA0B4;
  localparam logic [15:0] IDX_CLR_LOW = 16'hA0B5;
  localparam logic [15:0] IDX_CLR_HIGH = 16'hA0B6;
  localparam logic [15:0] IDX_WAKE_CONFIG = 16'hA0B7;
  localparam logic [15:0] IDX_ACTIVE = 16'hA0B8;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hA0C0;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hA0C1;
  // timeout configuration fields
  localparam int CFG_RX_BIT0 = 7;
  localparam int CFG_AUTO_EXIT = 6;
  localparam int CFG_RX_WAKE_EN = 5;
  localparam int CFG_TX_WAKE_EN = 4;
  localparam int CFG_RX_FLAG = 3;
  localparam int CFG_TX_FLAG = 2;
  localparam int CFG_RX_IRQ_EN = 1;
  localparam int CFG_TX_IRQ_EN = 0;
  // wakeup configuration fields
  localparam int WK_STUCK_FLAG = 7;
  localparam int WK_BUS_FLAG = 6;
  localparam int WK_STUCK_EN = 5;
  localparam int WK_BUS_EN = 4;
  localparam int WK_FILT_LSB = 0;
  localparam int WK_FILT_W = 4;
  // interrupt status and mask layout
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_STUCK = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [IRQ_W-1:0] RESET_IRQ = 4'h0;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // minimum address width to reach the highest index
  localparam int MIN_ADDR_W = 18;
  // bus-stuck watcher states
  typedef enum logic [1:0] {
    STK_WATCH = 2'b01,
    STK_STUCK = 2'b10
  } ldfm_stuck_type;
endpackage

// ### verilog/ldfm_monitor.sv
// dominant-timeout and bus-stuck fault monitor with an AXI4-Lite register slave
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps

// Function
// - TX dominant for 16-bit threshold plus one fast ticks flags a TX fault.
// - RX threshold is 17 bits; low byte gives bits 8-1, high byte 16-9.
// - Wakeup detection sets the wakeup flag; it holds until software clears it.
// - Bus-stuck events raise wakeup or interrupt only while stuck enable is set.
// - A bus-stuck detection is reported in the stuck flag of the wakeup config.
// - RX threshold bit 0 comes from the timeout configuration register.
// - RX and TX fault flags set by hardware, cleared by software, own enables.
// - With auto break exit enabled an RX fault ends the break state.
module ldfm_monitor #(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // line and oscillator ticks, dominant is low
  input wire logic i_line_tx,
  input wire logic i_line_rx,
  input wire logic i_fast_osc_tick,
  input wire logic i_slow_osc_tick,
  // break state handshake with the frame logic
  input wire logic i_in_break,
  output logic o_break_exit,
  // wakeup and interrupt
  output logic o_wakeup,
  output logic o_irq
);
  import ldfm_pkg::*;
  // refused at elaboration: the register index needs 16 bits above the byte lanes
  if (ADDR_W < MIN_ADDR_W) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end
  function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] shifted;
    shifted = addr >> 2;
    return shifted[15:0];
  endfunction

  function automatic logic index_mapped(input logic [15:0] idx);
    return (idx >= IDX_TIMEOUT_CONFIG && idx <= IDX_ACTIVE) || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
  endfunction
  // registers
  logic [7:0] cfg_reg, tx_low_reg, tx_high_reg, rx_low_reg, rx_high_reg;
  logic [7:0] clr_low_reg, clr_high_reg, wake_reg, active_reg;
  logic [IRQ_W-1:0] irq_status_reg, irq_mask_reg;
  // write channel
  logic aw_held_reg, w_held_reg, w_lane_reg, bvalid_reg, do_write, wr_lane;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg, wr_byte;
  logic [1:0] bresp_reg;
  logic [15:0] wr_idx;
  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready = !w_held_reg && !bvalid_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign wr_idx = word_index(aw_addr_reg);
  assign wr_byte = w_byte_reg;
  assign wr_lane = w_lane_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= RESET_BYTE;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_reg <= 1'b1;
        w_byte_reg <= i_wdata[7:0];
        w_lane_reg <= i_wstrb[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= index_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // software write strobes per register
  function automatic logic wr_hit(input logic [15:0] idx);
    return do_write && wr_lane && wr_idx == idx;
  endfunction
  // hardware events
  logic tx_event, rx_event, wake_event, stuck_event;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_low_reg <= RESET_BYTE;
      tx_high_reg <= RESET_BYTE;
      rx_low_reg <= RESET_BYTE;
      rx_high_reg <= RESET_BYTE;
      clr_low_reg <= RESET_BYTE;
      clr_high_reg <= RESET_BYTE;
      active_reg <= RESET_BYTE;
      irq_mask_reg <= RESET_IRQ;
    end else begin
      if (wr_hit(IDX_TX_TO_LOW)) tx_low_reg <= wr_byte;
      if (wr_hit(IDX_TX_TO_HIGH)) tx_high_reg <= wr_byte;
      if (wr_hit(IDX_RX_TO_LOW)) rx_low_reg <= wr_byte;
      if (wr_hit(IDX_RX_TO_HIGH)) rx_high_reg <= wr_byte;
      if (wr_hit(IDX_CLR_LOW)) clr_low_reg <= wr_byte;
      if (wr_hit(IDX_CLR_HIGH)) clr_high_reg <= wr_byte;
      if (wr_hit(IDX_ACTIVE)) active_reg <= wr_byte;
      if (wr_hit(IDX_IRQ_MASK)) irq_mask_reg <= wr_byte[IRQ_W-1:0];
    end
  end
  // fault flags clear on a written zero; a same-cycle hardware set wins
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg <= RESET_BYTE;
    end else begin
      if (wr_hit(IDX_TIMEOUT_CONFIG)) begin
        cfg_reg <= wr_byte & ~(8'h01 << CFG_RX_FLAG) & ~(8'h01 << CFG_TX_FLAG);
        cfg_reg[CFG_RX_FLAG] <= cfg_reg[CFG_RX_FLAG] & wr_byte[CFG_RX_FLAG];
        cfg_reg[CFG_TX_FLAG] <= cfg_reg[CFG_TX_FLAG] & wr_byte[CFG_TX_FLAG];
      end
      if (tx_event) cfg_reg[CFG_TX_FLAG] <= 1'b1;
      if (rx_event) cfg_reg[CFG_RX_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_reg <= RESET_BYTE;
    end else begin
      if (wr_hit(IDX_WAKE_CONFIG)) begin
        wake_reg[WK_STUCK_EN] <= wr_byte[WK_STUCK_EN];
        wake_reg[WK_BUS_EN] <= wr_byte[WK_BUS_EN];
        wake_reg[WK_FILT_LSB +: WK_FILT_W] <= wr_byte[WK_FILT_LSB +: WK_FILT_W];
        wake_reg[WK_BUS_FLAG] <= wake_reg[WK_BUS_FLAG] & wr_byte[WK_BUS_FLAG];
        wake_reg[WK_STUCK_FLAG] <= wake_reg[WK_STUCK_FLAG] & wr_byte[WK_STUCK_FLAG];
      end
      if (wake_event) wake_reg[WK_BUS_FLAG] <= 1'b1;
      if (stuck_event) wake_reg[WK_STUCK_FLAG] <= 1'b1;
    end
  end
  // interrupt status: set by enabled events, cleared by writing one
  logic [IRQ_W-1:0] irq_set;
  assign irq_set[IRQ_TX] = tx_event && cfg_reg[CFG_TX_IRQ_EN];
  assign irq_set[IRQ_RX] = rx_event && cfg_reg[CFG_RX_IRQ_EN];
  assign irq_set[IRQ_WAKE] = wake_event && wake_reg[WK_BUS_EN];
  assign irq_set[IRQ_STUCK] = stuck_event && wake_reg[WK_STUCK_EN];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_status_reg <= RESET_IRQ;
    end else if (wr_hit(IDX_IRQ_STATUS)) begin
      irq_status_reg <= (irq_status_reg & ~wr_byte[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  assign o_irq = |(irq_status_reg & irq_mask_reg);
  // wakeup stays a level while an enabled flag is pending
  assign o_wakeup = (wake_reg[WK_BUS_FLAG] && wake_reg[WK_BUS_EN]) ||
                    (wake_reg[WK_STUCK_FLAG] && wake_reg[WK_STUCK_EN]) ||
                    (cfg_reg[CFG_RX_FLAG] && cfg_reg[CFG_RX_WAKE_EN]) ||
                    (cfg_reg[CFG_TX_FLAG] && cfg_reg[CFG_TX_WAKE_EN]);
  // read channel, one cycle from address to data
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rd_byte;
  logic [15:0] rd_idx;
  assign o_arready = !rvalid_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign rd_idx = word_index(i_araddr);

  always_comb begin
    case (rd_idx)
      IDX_TIMEOUT_CONFIG: rd_byte = cfg_reg;
      IDX_TX_TO_LOW: rd_byte = tx_low_reg;
      IDX_TX_TO_HIGH: rd_byte = tx_high_reg;
      IDX_RX_TO_LOW: rd_byte = rx_low_reg;
      IDX_RX_TO_HIGH: rd_byte = rx_high_reg;
      IDX_CLR_LOW: rd_byte = clr_low_reg;
      IDX_CLR_HIGH: rd_byte = clr_high_reg;
      IDX_WAKE_CONFIG: rd_byte = wake_reg;
      IDX_ACTIVE: rd_byte = active_reg;
      IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status_reg};
      IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask_reg};
      default: rd_byte = RESET_BYTE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= index_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  // dominant timeout counters on fast ticks; one event per dominant episode
  logic [15:0] tx_thr, tx_cnt_reg;
  logic [16:0] rx_thr, rx_cnt_reg;
  logic tx_done_reg, rx_done_reg;
  assign tx_thr = {tx_high_reg, tx_low_reg};
  assign rx_thr = {rx_high_reg, rx_low_reg, cfg_reg[CFG_RX_BIT0]};
  assign tx_event = !i_line_tx && i_fast_osc_tick && !tx_done_reg && tx_cnt_reg == tx_thr;
  assign rx_event = !i_line_rx && i_fast_osc_tick && !rx_done_reg && rx_cnt_reg == rx_thr;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_cnt_reg <= 16'h0000;
      tx_done_reg <= 1'b0;
    end else if (i_line_tx) begin
      tx_cnt_reg <= 16'h0000;
      tx_done_reg <= 1'b0;
    end else if (tx_event) begin
      tx_done_reg <= 1'b1;
    end else if (i_fast_osc_tick && !tx_done_reg) begin
      tx_cnt_reg <= tx_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_cnt_reg <= 17'h00000;
      rx_done_reg <= 1'b0;
    end else if (i_line_rx) begin
      rx_cnt_reg <= 17'h00000;
      rx_done_reg <= 1'b0;
    end else if (rx_event) begin
      rx_done_reg <= 1'b1;
    end else if (i_fast_osc_tick && !rx_done_reg) begin
      rx_cnt_reg <= rx_cnt_reg + 17'h00001;
    end
  end
  // break exit pulse; only taken while the frame logic reports break
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_break_exit <= 1'b0;
    end else begin
      o_break_exit <= rx_event && cfg_reg[CFG_AUTO_EXIT] && i_in_break;
    end
  end
  // wakeup filter: rx dominant for filter value plus one slow ticks
  logic [WK_FILT_W-1:0] wk_cnt_reg;
  logic wk_done_reg;
  assign wake_event = !i_line_rx && i_slow_osc_tick && !wk_done_reg &&
                      wk_cnt_reg == wake_reg[WK_FILT_LSB +: WK_FILT_W];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wk_cnt_reg <= '0;
      wk_done_reg <= 1'b0;
    end else if (i_line_rx) begin
      wk_cnt_reg <= '0;
      wk_done_reg <= 1'b0;
    end else if (wake_event) begin
      wk_done_reg <= 1'b1;
    end else if (i_slow_osc_tick && !wk_done_reg) begin
      wk_cnt_reg <= wk_cnt_reg + 4'h1;
    end
  end
  // bus-stuck watcher: the clear width must pass before a new detection can arm
  ldfm_stuck_type stk_state_reg;
  logic [15:0] stk_cnt_reg;
  logic [15:0] clr_thr;
  assign clr_thr = {clr_high_reg, clr_low_reg};
  assign stuck_event = stk_state_reg == STK_WATCH && !i_line_rx && i_slow_osc_tick &&
                       stk_cnt_reg[7:0] == active_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stk_state_reg <= STK_WATCH;
      stk_cnt_reg <= 16'h0000;
    end else begin
      case (stk_state_reg)
        STK_WATCH: begin
          if (i_line_rx) begin
            stk_cnt_reg <= 16'h0000;
          end else if (stuck_event) begin
            stk_state_reg <= STK_STUCK;
            stk_cnt_reg <= 16'h0000;
          end else if (i_slow_osc_tick) begin
            stk_cnt_reg <= stk_cnt_reg + 16'h0001;
          end
        end
        STK_STUCK: begin
          if (!i_line_rx) begin
            stk_cnt_reg <= 16'h0000;
          end else if (i_slow_osc_tick && stk_cnt_reg == clr_thr) begin
            stk_state_reg <= STK_WATCH;
            stk_cnt_reg <= 16'h0000;
          end else if (i_slow_osc_tick) begin
            stk_cnt_reg <= stk_cnt_reg + 16'h0001;
          end
        end
        default: begin
          stk_state_reg <= STK_WATCH;
          stk_cnt_reg <= 16'h0000;
        end
      endcase
    end
  end
  // checks
  tx_flag_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    tx_event |=> cfg_reg[CFG_TX_FLAG]) else $error("tx fault flag not set");
  rx_flag_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rx_event |=> cfg_reg[CFG_RX_FLAG]) else $error("rx fault flag not set");
  rx_count_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_line_rx |=> rx_cnt_reg == 17'h00000) else $error("rx counter not cleared");
  tx_threshold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    tx_event |-> tx_cnt_reg == {tx_high_reg, tx_low_reg}) else $error("tx event off threshold");
  rx_bit0_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rx_event |-> rx_cnt_reg[0] == cfg_reg[CFG_RX_BIT0]) else $error("rx bit0 mismatch");
  wake_flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wake_reg[WK_BUS_FLAG] && !wr_hit(IDX_WAKE_CONFIG) |=> wake_reg[WK_BUS_FLAG])
    else $error("wakeup flag dropped");
  stuck_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !wake_reg[WK_STUCK_EN] |-> !irq_set[IRQ_STUCK]) else $error("stuck irq while disabled");
  stuck_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    stuck_event |=> wake_reg[WK_STUCK_FLAG] && stk_state_reg == STK_STUCK) else $error("stuck not reported");
  stuck_rearm_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    stk_state_reg == STK_STUCK && !i_line_rx |=> stk_state_reg == STK_STUCK) else $error("stuck left while dominant");
  break_exit_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_break_exit |-> $past(cfg_reg[CFG_AUTO_EXIT]) && $past(rx_event)) else $error("break exit without cause");
  irq_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(o_irq) |-> $past(|irq_set) || $past(wr_hit(IDX_IRQ_MASK))) else $error("irq without cause");
endmodule

// ### tb/ldfm_bus_model.sv
// bus line and transceiver model with the two oscillator tick sources
`timescale 1ns/100ps
module ldfm_bus_model #(
  parameter int FAST_DIV = 2,
  parameter int SLOW_DIV = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // stimulus, 1 pulls that side of the bus dominant
  input wire logic i_tx_dom,
  input wire logic i_rx_dom,
  // line levels and ticks
  output logic o_line_tx,
  output logic o_line_rx,
  output logic o_fast_tick,
  output logic o_slow_tick
);
  int fast_cnt;
  int slow_cnt;
  // pull-up on the bus: released means recessive; own tx is echoed on rx like a real transceiver
  assign o_line_tx = ~i_tx_dom;
  assign o_line_rx = ~(i_tx_dom | i_rx_dom);
  // slow period shortened far below 32 kHz so stuck widths finish in a short run
  assign o_fast_tick = (fast_cnt == FAST_DIV - 1);
  assign o_slow_tick = (slow_cnt == SLOW_DIV - 1);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fast_cnt <= 0;
      slow_cnt <= 0;
    end else begin
      fast_cnt <= (fast_cnt == FAST_DIV - 1) ? 0 : fast_cnt + 1;
      slow_cnt <= (slow_cnt == SLOW_DIV - 1) ? 0 : slow_cnt + 1;
    end
  end
endmodule

// ### tb/ldfm_monitor_tb_top.sv
// self-checking bench: register access, dominant timeouts, wakeup and stuck detection
`timescale 1ns/100ps
module ldfm_monitor_tb_top;
  import ldfm_pkg::*;
  localparam int CEIL = 20000;
  logic i_clk, i_resetn, awvalid, wvalid, arvalid, tx_dom, rx_dom, in_break, seen_exit;
  logic awready, wready, bvalid, arready, rvalid, line_tx, line_rx, fast_tick, slow_tick;
  logic break_exit, wakeup, irq;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdata_w;
  logic [1:0] resp, bresp, rresp;
  logic [15:0] regs [0:10];
  int err_count, checked, cycles;

  ldfm_monitor ldfm_monitor_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_awprot(3'h0), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'h1),
    .o_bvalid(bvalid), .i_bready(1'b1), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .i_arprot(3'h0), .o_rvalid(rvalid), .i_rready(1'b1), .o_rdata(rdata_w), .o_rresp(rresp),
    .i_line_tx(line_tx), .i_line_rx(line_rx), .i_fast_osc_tick(fast_tick), .i_slow_osc_tick(slow_tick),
    .i_in_break(in_break), .o_break_exit(break_exit), .o_wakeup(wakeup), .o_irq(irq));
  ldfm_bus_model ldfm_bus_model_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_tx_dom(tx_dom), .i_rx_dom(rx_dom),
    .o_line_tx(line_tx), .o_line_rx(line_rx), .o_fast_tick(fast_tick), .o_slow_tick(slow_tick));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang anywhere ends here as a mismatch
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == CEIL) begin
      err_count++;
      summarize();
    end
  end

  always @(posedge i_clk) begin
    if (break_exit === 1'b1) seen_exit <= 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    do begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic rd(input logic [15:0] idx);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    do begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdata = rdata_w;
    resp = rresp;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    rd(idx);
    check(rdata, {24'h000000, exp}, "register read");
    check(resp, RESP_OKAY, "read response");
  endtask

  task automatic ticks(input bit slow, input int n);
    repeat (n) begin
      do @(posedge i_clk); while ((slow ? slow_tick : fast_tick) !== 1'b1);
    end
  endtask

  function automatic logic obs(input int sel);
    case (sel)
      0: return irq;
      1: return wakeup;
      default: return break_exit;
    endcase
  endfunction

  // hold one line dominant for n ticks; the watched output must rise on the n-th tick, not before
  task automatic dom_run(input bit rx, input bit slow, input int n, input int sel);
    if (rx) rx_dom <= 1'b1;
    else tx_dom <= 1'b1;
    ticks(slow, n - 1);
    #1 check(obs(sel), 1'b0, "output before count");
    ticks(slow, 1);
    #1 check(obs(sel), 1'b1, "output at count");
    @(posedge i_clk);
    rx_dom <= 1'b0;
    tx_dom <= 1'b0;
    #1 check(break_exit, 1'b0, "exit pulse length");
  endtask

  initial begin
    i_resetn = 1'b0;
    {awvalid, wvalid, arvalid, tx_dom, rx_dom, in_break, seen_exit} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    regs = '{IDX_TX_TO_LOW, IDX_TX_TO_HIGH, IDX_RX_TO_LOW, IDX_RX_TO_HIGH, IDX_CLR_LOW, IDX_CLR_HIGH,
      IDX_ACTIVE, IDX_TIMEOUT_CONFIG, IDX_WAKE_CONFIG, IDX_IRQ_MASK, IDX_IRQ_STATUS};
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    for (int k = 0; k < 11; k++) rd_chk(regs[k], RESET_BYTE);
    for (int k = 0; k < 7; k++) begin
      wr(regs[k], 8'hA5 ^ 8'(k));
      rd_chk(regs[k], 8'hA5 ^ 8'(k));
    end
    rd(16'hA0BF);
    check(resp, RESP_SLVERR, "unmapped read");
    wr(16'hA0BF, 8'hFF);
    check(resp, RESP_SLVERR, "unmapped write");
    // transmit timeout, low byte then high byte of the threshold
    wr(IDX_CLR_LOW, 8'h01);
    wr(IDX_CLR_HIGH, 8'h00);
    wr(IDX_ACTIVE, 8'h00);
    wr(IDX_TX_TO_LOW, 8'h03);
    wr(IDX_TX_TO_HIGH, 8'h00);
    wr(IDX_TIMEOUT_CONFIG, 8'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    dom_run(0, 0, 4, 0);
    wr(IDX_IRQ_STATUS, 8'h01);
    #1 check(irq, 1'b0, "irq after clear");
    wr(IDX_TX_TO_LOW, 8'h00);
    wr(IDX_TX_TO_HIGH, 8'h01);
    dom_run(0, 0, 257, 0);
    wr(IDX_IRQ_MASK, 8'h00);
    #1 check(irq, 1'b0, "irq masked");
    rd_chk(IDX_IRQ_STATUS, 8'h01);
    rd_chk(IDX_TIMEOUT_CONFIG, 8'h05);
    rd_chk(IDX_WAKE_CONFIG, 8'hC0);
    wr(IDX_TIMEOUT_CONFIG, 8'h01);
    rd_chk(IDX_TIMEOUT_CONFIG, 8'h01);
    wr(IDX_IRQ_STATUS, 8'h01);
    rd_chk(IDX_IRQ_STATUS, 8'h00);
    // receive timeout: threshold 5 built from bit 0 in config and bits 8-1 in the low byte
    wr(IDX_RX_TO_LOW, 8'h02);
    wr(IDX_RX_TO_HIGH, 8'h00);
    wr(IDX_TIMEOUT_CONFIG, 8'hC2);
    in_break <= 1'b1;
    dom_run(1, 0, 6, 2);
    rd_chk(IDX_IRQ_STATUS, 8'h02);
    wr(IDX_IRQ_STATUS, 8'h02);
    wr(IDX_IRQ_MASK, 8'h02);
    wr(IDX_TIMEOUT_CONFIG, 8'hA2);
    seen_exit <= 1'b0;
    dom_run(1, 0, 6, 0);
    check(seen_exit, 1'b0, "exit while disabled");
    check(wakeup, 1'b1, "rx timeout wakeup");
    // wakeup filter 2 then bus-stuck active width 4, clear width 1
    wr(IDX_IRQ_STATUS, 8'h0F);
    wr(IDX_IRQ_MASK, 8'h08);
    wr(IDX_ACTIVE, 8'h04);
    wr(IDX_WAKE_CONFIG, 8'h12);
    wr(IDX_TIMEOUT_CONFIG, 8'h82);
    #1 check(wakeup, 1'b0, "rx wakeup after clear");
    ticks(1, 2);
    dom_run(1, 1, 3, 1);
    rd_chk(IDX_WAKE_CONFIG, 8'h52);
    wr(IDX_WAKE_CONFIG, 8'h12);
    #1 check(wakeup, 1'b0, "wakeup after clear");
    ticks(1, 2);
    wr(IDX_WAKE_CONFIG, 8'h22);
    dom_run(1, 1, 5, 0);
    check(wakeup, 1'b1, "stuck wakeup");
    rd_chk(IDX_WAKE_CONFIG, 8'hE2);
    wr(IDX_IRQ_STATUS, 8'h08);
    #1 check(irq, 1'b0, "irq after stuck clear");
    summarize();
  end
endmodule
